// [hdl/sph_pkg.sv]
// Shared constants and types for the serial pause link
package sph_pkg;
    localparam int SPH_WORD_BITS = 8;
    localparam int SPH_CNT_BITS = 3;
    localparam int SPH_DIV_HALF = 4;
    localparam logic [7:0] SPH_DATA_RST = 8'h00;
    localparam logic [2:0] SPH_CNT_RST = 3'h0;
    typedef enum logic [1:0] {
        SPH_IDLE = 2'b00,
        SPH_SHIFT = 2'b01,
        SPH_PAUSED = 2'b10
    } sph_state_type;
endpackage : sph_pkg

// [hdl/sph_if.sv]
// Interface joining the serial master and the paused serial slave
`timescale 1ns/1ns
interface sph_if;
    logic select_n;
    logic serial_clock;
    logic serial_in;
    logic pause_n;
    logic serial_out_o;
    logic serial_out_oe;
    logic serial_out;
    // Released line reads as inverted data, so a sample taken too late shows up
    assign serial_out = serial_out_oe ? serial_out_o : ~serial_out_o;
    modport slave (
        input select_n,
        input serial_clock,
        input serial_in,
        input pause_n,
        output serial_out_o,
        output serial_out_oe
    );
    modport master (
        output select_n,
        output serial_clock,
        output serial_in,
        output pause_n,
        input serial_out
    );
endinterface : sph_if

// [hdl/sph_slave.sv]
// Serial slave port with pause control, oversampling the link pins
// Functional notes
// - Master keeps pause_n high unless pausing
// - Pause low while selected suspends, keeps state
// - Master lowers pause_n only with clock low
// - Pause during clock high waits falling edge
// - Master keeps select low while paused
// - Paused: ignore clock, input, output
// - Resume only if release during clock low
// - Pause low always tristates serial output
// - Sample input rising, update output falling
// - Deselect tristates output, frees bus
`timescale 1ns/1ns
module sph_slave
    import sph_pkg::*;
#(
    parameter int WORD_BITS = sph_pkg::SPH_WORD_BITS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    sph_if.slave link,
    input wire logic [WORD_BITS-1:0] tx_word,
    output logic tx_load,
    output logic [WORD_BITS-1:0] rx_word,
    output logic rx_valid,
    output logic paused
);
    import sph_pkg::*;
    localparam int CW = $clog2(WORD_BITS);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sel_sync_reg;
    // Reset deselected, so no false select follows reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sel_sync_reg <= 2'h3;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], link.select_n};
        end
    end

    logic [1:0] sck_sync_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sck_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], link.serial_clock};
        end
    end

    logic [1:0] si_sync_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            si_sync_reg <= 2'h0;
        end else begin
            si_sync_reg <= {si_sync_reg[0], link.serial_in};
        end
    end

    logic [1:0] hold_sync_reg;
    // Reset released: the pause pin idles high
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hold_sync_reg <= 2'h3;
        end else begin
            hold_sync_reg <= {hold_sync_reg[0], link.pause_n};
        end
    end
    wire logic sel_n = sel_sync_reg[1];
    wire logic sck = sck_sync_reg[1];
    wire logic si = si_sync_reg[1];
    wire logic hold_n = hold_sync_reg[1];

    logic sck_last_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sck_last_reg <= 1'b0;
        end else begin
            sck_last_reg <= sck;
        end
    end

    // Reset at the pin's idle level, so no false edge follows reset
    logic hold_last_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hold_last_reg <= 1'b1;
        end else begin
            hold_last_reg <= hold_n;
        end
    end
    wire logic sck_rise = sck & ~sck_last_reg;
    wire logic sck_fall = ~sck & sck_last_reg;
    wire logic hold_rise = hold_n & ~hold_last_reg;

    // ----------------------------------------
    // Pause state machine
    // ----------------------------------------
    sph_state_type state_reg, state_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPH_IDLE: begin
                if (!sel_n) state_next = SPH_SHIFT;
            end
            SPH_SHIFT: begin
                // Pause with clock high only bites on the falling edge
                if (!hold_n && (!sck || sck_fall)) state_next = SPH_PAUSED;
            end
            SPH_PAUSED: begin
                // Release seen with clock high is ignored; master must retry
                if (hold_rise && !sck) state_next = SPH_SHIFT;
            end
            default: state_next = SPH_IDLE;
        endcase
        if (sel_n) state_next = SPH_IDLE;
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) state_reg <= SPH_IDLE;
        else state_reg <= state_next;
    end
    wire logic active = (state_reg == SPH_SHIFT) && (state_next == SPH_SHIFT);

    // ----------------------------------------
    // Shift path; counter kept across a pause
    // ----------------------------------------
    logic [CW-1:0] cnt_reg;
    logic [WORD_BITS-1:0] rx_sh_reg, tx_sh_reg;
    logic so_reg;

    // Bit position decodes shared by receive and transmit
    function automatic logic cnt_last(input logic [CW-1:0] cnt);
        cnt_last = (cnt == CW'(WORD_BITS - 1));
    endfunction : cnt_last
    function automatic logic cnt_first(input logic [CW-1:0] cnt);
        cnt_first = (cnt == '0);
    endfunction : cnt_first

    // No step while paused: pin motion then is ignored
    wire logic rx_step = active && sck_rise;
    wire logic tx_step = active && sck_fall;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= CW'(SPH_CNT_RST);
        end else if (state_reg == SPH_IDLE) begin
            // A dropped frame loses its partial word
            cnt_reg <= CW'(SPH_CNT_RST);
        end else if (rx_step) begin
            cnt_reg <= cnt_last(cnt_reg) ? '0 : cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sh_reg <= WORD_BITS'(SPH_DATA_RST);
        end else if (rx_step) begin
            rx_sh_reg <= {rx_sh_reg[WORD_BITS-2:0], si};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_word <= WORD_BITS'(SPH_DATA_RST);
        end else if (rx_step && cnt_last(cnt_reg)) begin
            rx_word <= {rx_sh_reg[WORD_BITS-2:0], si};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= rx_step && cnt_last(cnt_reg);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sh_reg <= WORD_BITS'(SPH_DATA_RST);
        end else if (tx_load) begin
            tx_sh_reg <= tx_word;
        end else if (tx_step) begin
            tx_sh_reg <= {tx_sh_reg[WORD_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            so_reg <= 1'b0;
        end else if (tx_load) begin
            so_reg <= tx_word[WORD_BITS-1];
        end else if (tx_step) begin
            so_reg <= tx_sh_reg[WORD_BITS-2];
        end
    end

    // Word taken whenever idle, so its first bit already stands at select
    assign tx_load = (state_reg == SPH_IDLE) || (tx_step && cnt_first(cnt_reg));
    assign paused = (state_reg == SPH_PAUSED);
    assign link.serial_out_o = so_reg;
    // Raw pause pin used so tristate is immediate, not two cycles late
    assign link.serial_out_oe = !link.pause_n ? 1'b0
                              : (state_reg == SPH_SHIFT) && !sel_n;
endmodule : sph_slave

// [hdl/sph_master.sv]
// Serial master driving clock, select and pause for the slave
`timescale 1ns/1ns
module sph_master
    import sph_pkg::*;
#(
    parameter int WORD_BITS = sph_pkg::SPH_WORD_BITS,
    parameter int DIV_HALF = sph_pkg::SPH_DIV_HALF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    sph_if.master link,
    input wire logic start,
    input wire logic [WORD_BITS-1:0] tx_word,
    input wire logic pause_req,
    output logic busy,
    output logic [WORD_BITS-1:0] rx_word,
    output logic done
);
    import sph_pkg::*;
    localparam int CW = $clog2(WORD_BITS) + 1;
    localparam int DW = $clog2(DIV_HALF) + 1;

    logic [1:0] so_sync_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) so_sync_reg <= 2'h0;
        else so_sync_reg <= {so_sync_reg[0], link.serial_out};
    end

    // ----------------------------------------
    // Half-period divider
    // ----------------------------------------
    logic [DW-1:0] div_reg;
    wire logic tick = (div_reg == DW'(DIV_HALF - 1));
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) div_reg <= '0;
        else div_reg <= tick ? '0 : div_reg + 1'b1;
    end

    logic sel_n_reg, sck_reg, si_reg, hold_n_reg;
    logic [CW-1:0] bits_reg;
    logic [WORD_BITS-1:0] tx_sh_reg, rx_sh_reg;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sel_n_reg <= 1'b1;
            sck_reg <= 1'b0;
            si_reg <= 1'b0;
            hold_n_reg <= 1'b1;
            bits_reg <= '0;
            tx_sh_reg <= '0;
            rx_sh_reg <= '0;
            rx_word <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (sel_n_reg) begin
                if (start && tick) begin
                    sel_n_reg <= 1'b0;
                    si_reg <= tx_word[WORD_BITS-1];
                    tx_sh_reg <= {tx_word[WORD_BITS-2:0], 1'b0};
                    bits_reg <= '0;
                end
            end else if (tick) begin
                if (!sck_reg) begin
                    // Pause edges placed only while clock is low
                    if (hold_n_reg != !pause_req) begin
                        hold_n_reg <= !pause_req;
                    end else if (hold_n_reg && bits_reg == CW'(WORD_BITS)) begin
                        sel_n_reg <= 1'b1;
                        rx_word <= rx_sh_reg;
                        done <= 1'b1;
                    end else if (hold_n_reg) begin
                        sck_reg <= 1'b1;
                        bits_reg <= bits_reg + 1'b1;
                    end
                end else begin
                    // Read back late in the high phase: both synchronisers cost more
                    // than half a period, so the bit is not settled at the rise
                    rx_sh_reg <= {rx_sh_reg[WORD_BITS-2:0], so_sync_reg[1]};
                    sck_reg <= 1'b0;
                    si_reg <= tx_sh_reg[WORD_BITS-1];
                    tx_sh_reg <= {tx_sh_reg[WORD_BITS-2:0], 1'b0};
                end
            end
        end
    end
    assign link.select_n = sel_n_reg;
    assign link.serial_clock = sck_reg;
    assign link.serial_in = si_reg;
    assign link.pause_n = hold_n_reg;
    assign busy = !sel_n_reg;
endmodule : sph_master

// [verif/sph_link_assertions.sv]
// Checker on the signals of the pause link
`timescale 1ns/1ns
module sph_link_assertions (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic select_n,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic pause_n,
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    property p_pause_off; !pause_n |-> !serial_out_oe; endproperty
    a_pause_off: assert property (p_pause_off) else $error("out driven in pause");
    // Four cycles allowed for the slave to see the pin
    property p_desel_off; select_n [*4] |-> !serial_out_oe; endproperty
    a_desel_off: assert property (p_desel_off) else $error("out driven idle");
    property p_pause_low; $fell(pause_n) |-> !serial_clock; endproperty
    a_pause_low: assert property (p_pause_low) else $error("pause at clock high");
    property p_resume_low; $rose(pause_n) |-> !serial_clock; endproperty
    a_resume_low: assert property (p_resume_low) else $error("resume at clock high");
    property p_pause_sel; !pause_n |-> !select_n; endproperty
    a_pause_sel: assert property (p_pause_sel) else $error("pause unselected");
    property p_frozen; !pause_n && !$past(pause_n) |-> $stable(serial_clock) && $stable(serial_in);
    endproperty
    a_frozen: assert property (p_frozen) else $error("pins move in pause");
    property p_out_fall;
        $changed(serial_out_o) && serial_out_oe && $past(serial_out_oe)
            |-> !serial_clock || !$past(serial_clock, 2);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("out moved at clock high");
    property p_resume_drv; $rose(pause_n) ##0 !select_n |-> ##[1:8] serial_out_oe; endproperty
    a_resume_drv: assert property (p_resume_drv) else $error("no drive after resume");
    c_pause: cover property ($fell(pause_n) ##[1:300] $rose(pause_n));
    c_desel: cover property ($rose(select_n));
    c_sel: cover property ($fell(select_n));
endmodule : sph_link_assertions

// [verif/tb.sv]
// Bench: master and slave facing each other over the link
`timescale 1ns/1ns
module tb;
    import sph_pkg::*;
    logic clk_sys;
    logic sys_rst;
    logic start;
    logic pause_req;
    logic busy;
    logic done;
    logic s_load;
    logic s_valid;
    logic s_paused;
    logic [7:0] m_tx;
    logic [7:0] s_tx;
    logic [7:0] m_rx;
    logic [7:0] s_rx;
    int bad_count;
    int checked;
    int valid_seen = 0;
    sph_if link ();
    sph_master i_sph_master (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.master),
        .start(start), .tx_word(m_tx), .pause_req(pause_req), .busy(busy), .rx_word(m_rx),
        .done(done));
    sph_slave i_sph_slave (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.slave),
        .tx_word(s_tx), .tx_load(s_load), .rx_word(s_rx), .rx_valid(s_valid),
        .paused(s_paused));
    sph_link_assertions i_sph_link_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .select_n(link.select_n), .serial_clock(link.serial_clock), .serial_in(link.serial_in),
        .pause_n(link.pause_n), .serial_out_o(link.serial_out_o),
        .serial_out_oe(link.serial_out_oe));
    // Received-word pulses, counted clear of the launching edge
    always @(negedge clk_sys) begin
        if (s_valid === 1'b1) valid_seen++;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Sampled on the falling edge, clear of register updates
    task automatic wait_on(input int which);
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n > 1000) begin
                bad_count++;
                $display("unexpected at %0t: wait %h limit %h", $time, which, n);
                test_done();
            end
        end while (!((which == 0 && busy === 1'h1) || (which == 1 && done === 1'h1)
            || (which == 2 && s_paused === 1'h1)));
    endtask : wait_on
    task automatic xfer(input logic [7:0] mt, input logic [7:0] st, input int hold_at);
        int seen;
        seen = valid_seen;
        @(posedge clk_sys);
        m_tx <= mt;
        s_tx <= st;
        start <= 1'h1;
        wait_on(0);
        @(posedge clk_sys);
        start <= 1'h0;
        if (hold_at > 0) begin
            repeat (hold_at) @(posedge clk_sys);
            pause_req <= 1'h1;
            wait_on(2);
            check({7'h00, link.serial_out_oe}, 8'h00);
            repeat (40) @(posedge clk_sys);
            check({7'h00, s_paused}, 8'h01);
            pause_req <= 1'h0;
        end
        wait_on(1);
        check(m_rx, st);
        check(s_rx, mt);
        check(8'(valid_seen - seen), 8'h01);
        repeat (6) @(negedge clk_sys);
        check({5'h00, s_load, link.select_n, link.serial_out_oe}, 8'h06);
    endtask : xfer
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_plain();
        xfer(8'hA5, 8'h3C, 0);
        xfer(8'h00, 8'hFF, 0);
        xfer(8'hFF, 8'h00, 0);
        $display("test plain finished");
    endtask : test_plain
    // Pause mid-word and at the very first bit, back to back
    task automatic test_pause();
        xfer(8'h96, 8'h69, 30);
        xfer(8'hC3, 8'h5A, 1);
        $display("test pause finished");
    endtask : test_pause
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        sys_rst = 1'h1;
        start = 1'h0;
        pause_req = 1'h0;
        m_tx = 8'h00;
        s_tx = 8'h00;
        bad_count = 0;
        checked = 0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        test_plain();
        test_pause();
        test_done();
    end
endmodule : tb
